// ===== test/cafs_frame_src.sv
// Purpose: Stands in for the engine handing over received identifiers.
// Assumes: Fields only mean something in the valid cycle.
// Notes: After that cycle the fields show the inverse of the last frame.
`timescale 1ns/10ps
`default_nettype none
module cafs_frame_src (
  input wire logic i_ref_clk, // Clock
  output logic o_frame_valid, // Identifier pulse
  output logic o_frame_ext, // Extended frame
  output logic [10:0] o_frame_sid, // Standard part
  output logic [17:0] o_frame_eid // Extended part
);
  // Idle at time zero
  initial begin
    o_frame_valid = 1'b0;
    o_frame_ext = 1'b0;
    o_frame_sid = 11'h000;
    o_frame_eid = 18'h00000;
  end
  // One frame for one cycle, then scrambled fields
  task automatic send(input logic ext, input logic [10:0] standard_ident_bits,
                      input logic [17:0] extended_ident_bits);
    @(posedge i_ref_clk);
    o_frame_valid <= 1'b1;
    o_frame_ext <= ext;
    o_frame_sid <= standard_ident_bits;
    o_frame_eid <= extended_ident_bits;
    @(posedge i_ref_clk);
    o_frame_valid <= 1'b0;
    o_frame_ext <= ~ext;
    o_frame_sid <= ~standard_ident_bits;
    o_frame_eid <= ~extended_ident_bits;
  endtask : send
endmodule : cafs_frame_src
`default_nettype wire

// ===== test/cafs_top_chk.sv
// Purpose: Timing checks on the ports of cafs_top.
// Assumes: One clock, synchronous high reset.
// Notes: Bound into every cafs_top.
`timescale 1ns/10ps
`default_nettype none
module cafs_top_chk #(
  parameter int ADDR_W = 12 // Address width
) (
  input wire logic i_ref_clk, // Clock
  input wire logic i_rst, // Reset
  input wire logic i_psel, // Select
  input wire logic i_penable, // Enable
  input wire logic i_pwrite, // Write
  input wire logic [ADDR_W-1:0] i_paddr, // Address
  input wire logic [31:0] o_prdata, // Read data
  input wire logic o_pready, // Ready
  input wire logic o_pslverr, // Error
  input wire logic i_frame_valid, // Frame pulse
  input wire logic o_hit_valid, // Result pulse
  input wire logic o_hit, // Hit
  input wire logic [3:0] o_hit_filter, // Winner
  input wire logic [3:0] o_hit_buffer, // Pointer
  input wire logic o_hit_fifo // To FIFO
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // Bus phases
  sequence apb_setup;
    i_psel && !i_penable;
  endsequence
  sequence apb_answer;
    o_pready ##1 !o_pready;
  endsequence
  // Bus answers
  ready_timing_a: assert property (apb_setup |=> apb_answer)
    else $error("ready not one cycle after setup");
  misalign_err_a: assert property (apb_setup and (i_paddr[1:0] != 2'h0)
    |=> o_pslverr) else $error("misaligned access without error");
  read_upper_a: assert property (o_pready && !i_pwrite
    |-> o_prdata[31:16] == 16'h0000) else $error("upper read bits set");
  // Filter results
  result_pulse_a: assert property (i_frame_valid |=> o_hit_valid)
    else $error("result late");
  result_cause_a: assert property (o_hit_valid |-> $past(i_frame_valid))
    else $error("result without frame");
  fifo_steer_a: assert property (o_hit_valid
    |-> o_hit_fifo == (o_hit && o_hit_buffer == 4'hf))
    else $error("fifo flag wrong");
  miss_zero_a: assert property (o_hit_valid && !o_hit
    |-> o_hit_filter == 4'h0 && o_hit_buffer == 4'h0 && !o_hit_fifo)
    else $error("miss not zero");
  result_held_a: assert property (!i_frame_valid
    |=> $stable({o_hit, o_hit_filter, o_hit_buffer, o_hit_fifo}))
    else $error("result changed without frame");
  reset_quiet_a: assert property (disable iff (1'b0) i_rst
    |=> !o_hit_valid && !o_pready && !o_hit) else $error("busy in reset");
endmodule : cafs_top_chk
bind cafs_top cafs_top_chk #(.ADDR_W(ADDR_W)) cafs_top_chk_i (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_frame_valid(i_frame_valid), .o_hit_valid(o_hit_valid),
  .o_hit(o_hit), .o_hit_filter(o_hit_filter),
  .o_hit_buffer(o_hit_buffer), .o_hit_fifo(o_hit_fifo));
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: Self-checking bench for cafs_top.
// Assumes: Answer after setup, result one cycle after a frame.
// Notes: Rows hold frames and the steering they should give.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct {
    logic ext;
    logic [10:0] standard_ident_bits;
    logic [17:0] extended_ident_bits;
    logic [8:0] exp;
  } cafs_row_s;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h00000000;
  logic [3:0] i_pstrb = 4'hf;
  logic [31:0] o_prdata, rd;
  logic o_pready, o_pslverr, se, fv, fe, o_hit_valid, o_hit, o_hit_fifo;
  logic [10:0] fs;
  logic [17:0] fx;
  logic [3:0] o_hit_filter, o_hit_buffer;
  int bad_count = 0;
  int n_checks = 0;
  // Setup: enables, selectors, pointers, masks, filters
  logic [11:0] ca [15] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h01c,
    12'h020, 12'h030, 12'h024, 12'h034, 12'h040, 12'h044, 12'h084,
    12'h048, 12'h088, 12'h060};
  logic [15:0] cd [15] = '{16'h8107, 16'h0010, 16'h8001, 16'h0ef3,
    16'h9000, 16'hffeb, 16'hffff, 16'hffe0, 16'h00ff, 16'h2460,
    16'h8aca, 16'habcd, 16'h6420, 16'h005a, 16'hffe0};
  // Frames and {hit, filter, pointer} expected
  cafs_row_s rows [11] = '{
    '{1'b0, 11'h123, 18'h00000, 9'h103},
    '{1'b0, 11'h122, 18'h00000, 9'h1f9},
    '{1'b1, 11'h123, 18'h00000, 9'h1f9},
    '{1'b1, 11'h456, 18'h2abcd, 9'h11f},
    '{1'b1, 11'h456, 18'h1abcd, 9'h1f9},
    '{1'b1, 11'h456, 18'h2abcc, 9'h1f9},
    '{1'b0, 11'h456, 18'h00000, 9'h1f9},
    '{1'b1, 11'h321, 18'h3ff5a, 9'h12e},
    '{1'b0, 11'h321, 18'h00000, 9'h12e},
    '{1'b1, 11'h321, 18'h0005b, 9'h1f9},
    '{1'b0, 11'h7ff, 18'h00000, 9'h180}};
  always #12.5 i_ref_clk = ~i_ref_clk;
  cafs_top cafs_top_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_frame_valid(fv), .i_frame_ext(fe), .i_frame_sid(fs),
    .i_frame_eid(fx), .o_hit_valid(o_hit_valid), .o_hit(o_hit),
    .o_hit_filter(o_hit_filter), .o_hit_buffer(o_hit_buffer),
    .o_hit_fifo(o_hit_fifo));
  cafs_frame_src cafs_frame_src_i (.i_ref_clk(i_ref_clk),
    .o_frame_valid(fv), .o_frame_ext(fe), .o_frame_sid(fs),
    .o_frame_eid(fx));
  // Count a comparison, report a difference
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One bus transfer, held until ready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge i_ref_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      bad_count++;
      final_report();
    end
    rd = o_prdata;
    se = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  // Send a frame and compare the steering
  task automatic frm(input cafs_row_s r);
    cafs_frame_src_i.send(r.ext, r.standard_ident_bits, r.extended_ident_bits);
    #1;
    chk("valid", 32'h1, {31'h0, o_hit_valid});
    chk("steer", {23'h0, r.exp},
        {23'h0, o_hit, o_hit_filter, o_hit_buffer});
    chk("fifo", {31'h0, r.exp[8] && r.exp[3:0] == 4'hf},
        {31'h0, o_hit_fifo});
  endtask : frm
  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // Hang guard
  initial begin
    repeat (50000) @(posedge i_ref_clk);
    bad_count++;
    final_report();
  end
  // Main sequence; selectors never use the reserved code
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      apb(1'b1, ca[i], {16'h0, cd[i]});
      apb(1'b0, ca[i], 32'h0);
      chk("readback", {16'h0, cd[i]}, rd);
    end
    $display("test readback done");
    foreach (rows[i]) frm(rows[i]);
    $display("test rows done");
    apb(1'b1, 12'h000, 32'h00000106);
    frm('{1'b0, 11'h123, 18'h00000, 9'h000});
    $display("test enable done");
    apb(1'b1, 12'h07c, 32'h00000014);
    apb(1'b0, 12'h07c, 32'h0);
    chk("unimpl bits", 32'h0, rd);
    apb(1'b1, 12'h002, 32'h0000ffff);
    chk("misaligned", 32'h1, {31'h0, se});
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped", 32'h1, {31'h0, se});
    chk("unmapped data", 32'h0, rd);
    apb(1'b0, 12'h000, 32'h0);
    chk("enable kept", 32'h00000106, rd);
    $display("test bus errors done");
    i_rst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ca[i], 32'h0);
      chk("reset value", (i == 0) ? 32'h0000ffff : 32'h0, rd);
    end
    $display("test reset done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire

// ===== verilog/cafs_match.sv
// Purpose: Compares one received identifier against all filters.
// Assumes: Frame fields stable while sampled by the caller.
// Notes: Combinational; reserved mask code gives no hit.
`timescale 1ns/10ps
`default_nettype none
module cafs_match (
  cafs_match_if.mat m // Frame, setup and hit vector
);
  // Evaluate each filter with its chosen mask
  always_comb begin
    logic [1:0] sel;
    logic [15:0] ms;
    logic [15:0] me;
    logic sid_ok;
    logic eid_ok;
    logic type_ok;
    sel = 2'h0;
    ms = 16'h0000;
    me = 16'h0000;
    sid_ok = 1'b0;
    eid_ok = 1'b0;
    type_ok = 1'b0;
    m.hit = 16'h0000;
    for (int f = 0; f < cafs_pkg::NUM_FILT; f++) begin
      sel = m.msel[2*f +: 2];
      // Mask source 00, 01, 10
      case (sel)
        2'h0: begin ms = m.msid[0]; me = m.meid[0]; end
        2'h1: begin ms = m.msid[1]; me = m.meid[1]; end
        2'h2: begin ms = m.msid[2]; me = m.meid[2]; end
        default: begin ms = 16'h0000; me = 16'h0000; end
      endcase
      // Standard bits compared only where mask is one
      sid_ok = (((m.fsid[f][cafs_pkg::SID_MSB:cafs_pkg::SID_LSB]
                  ^ m.fr_sid)
                 & ms[cafs_pkg::SID_MSB:cafs_pkg::SID_LSB]) == 11'h000);
      // All 18 extended bits under the mask
      eid_ok = ((({m.fsid[f][cafs_pkg::EIDH_MSB:0], m.feid[f]}
                  ^ m.fr_eid)
                 & {ms[cafs_pkg::EIDH_MSB:0], me}) == 18'h00000);
      // Type qualifier against the extended select bit
      type_ok = !ms[cafs_pkg::TYPE_BIT] ||
                (m.fsid[f][cafs_pkg::TYPE_BIT] == m.fr_ext);
      m.hit[f] = m.fen[f] && (sel != cafs_pkg::MSK_RESERVED) &&
                 type_ok && sid_ok && (!m.fr_ext || eid_ok);
    end
  end
endmodule : cafs_match
`default_nettype wire

// ===== verilog/cafs_match_if.sv
// Purpose: Carries frame identifier and filter setup to the matcher.
// Assumes: One clock domain, purely combinational use.
// Notes: Config side drives, matcher returns a hit vector.
`timescale 1ns/10ps
`default_nettype none
interface cafs_match_if;
  logic fr_ext;
  logic [10:0] fr_sid;
  logic [17:0] fr_eid;
  logic [15:0] fen;
  logic [31:0] msel;
  logic [15:0] fsid [cafs_pkg::NUM_FILT];
  logic [15:0] feid [cafs_pkg::NUM_FILT];
  logic [15:0] msid [cafs_pkg::NUM_MASK];
  logic [15:0] meid [cafs_pkg::NUM_MASK];
  logic [15:0] hit;
  modport cfg (output fr_ext, fr_sid, fr_eid, fen, msel, fsid, feid,
               output msid, meid, input hit);
  modport mat (input fr_ext, fr_sid, fr_eid, fen, msel, fsid, feid,
               input msid, meid, output hit);
endinterface : cafs_match_if
`default_nettype wire

// ===== verilog/cafs_pkg.sv
// Purpose: Constants for the CAN acceptance filter and buffer steering.
// Assumes: 32-bit APB data, 16-bit registers in the low half of a word.
// Notes: All offsets are byte addresses of aligned words.
`default_nettype none
package cafs_pkg;
  // Sizes
  localparam int NUM_FILT = 16;
  localparam int NUM_MASK = 3;
  localparam int ADDR_W = 12;
  // Register byte offsets
  localparam logic [11:0] OFF_FEN = 12'h000;
  localparam logic [11:0] OFF_MSEL_LO = 12'h004;
  localparam logic [11:0] OFF_MSEL_HI = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_BUFP1 = 12'h010;
  localparam logic [11:0] OFF_BUFP2 = 12'h014;
  localparam logic [11:0] OFF_BUFP3 = 12'h018;
  localparam logic [11:0] OFF_BUFP4 = 12'h01c;
  localparam logic [11:0] OFF_MSID_BASE = 12'h020;
  localparam logic [11:0] OFF_MEID_BASE = 12'h030;
  localparam logic [11:0] OFF_FSID_BASE = 12'h040;
  localparam logic [11:0] OFF_FEID_BASE = 12'h080;
  // Reset values
  localparam logic [15:0] FEN_RST = 16'hffff;
  localparam logic [15:0] MSEL_RST = 16'h0000;
  localparam logic [15:0] BUFP_RST = 16'h0000;
  localparam logic [15:0] IDENT_RST = 16'h0000;
  // Field layout of the standard-identifier words
  localparam int SID_MSB = 15;
  localparam int SID_LSB = 5;
  localparam int TYPE_BIT = 3;
  localparam int EIDH_MSB = 1;
  localparam logic [15:0] SID_WMASK = 16'hffeb;
  // Codes
  localparam logic [1:0] MSK_RESERVED = 2'h3;
  localparam logic [3:0] BP_FIFO = 4'hf;
  // Status word fields
  localparam int ST_SEEN = 15;
  localparam int ST_HIT = 9;
  localparam int ST_FIFO = 8;
  localparam int ST_FILT_LSB = 4;
endpackage : cafs_pkg
`default_nettype wire

// ===== verilog/cafs_top.sv
// Purpose: APB register file, acceptance filtering and buffer steering.
// Assumes: Frame fields synchronous to i_ref_clk, valid with a pulse.
// Notes: Lowest numbered hitting filter wins; result one cycle later.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Masked extended bits 15..0 must equal the filter extended word.
// - Standard bits compared only where the mask bit is one.
// - Type qualifier set: frame type must match filter extended select.
// - Qualifier clear: either type; std uses 11 bits, ext uses 29.
// - All 18 extended mask bits apply; zero means don't care.
// - Mask source 00, 01, 10 picks mask 0, 1, 2.
// - Selectors of filters 0..7 in low word, 8..15 in high word.
// - Buffer pointer 1111 steers the hit to the receive FIFO.
// - Pointer 0000..1110 steers to the buffer of that index.
// - Four pointers per word, filter 0 in bits 3..0.
// - With qualifier, select set means extended only, clear standard.
// - A filter is evaluated only while its enable bit is set.
module cafs_top #(
  parameter int ADDR_W = cafs_pkg::ADDR_W // APB address width
) (
  input wire logic i_ref_clk, // Clock, 40 MHz
  input wire logic i_rst, // Synchronous reset, high
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB write
  input wire logic [ADDR_W-1:0] i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  input wire logic [3:0] i_pstrb, // APB byte strobes
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error, unmapped
  input wire logic i_frame_valid, // Received identifier pulse
  input wire logic i_frame_ext, // Frame is extended
  input wire logic [10:0] i_frame_sid, // Standard identifier
  input wire logic [17:0] i_frame_eid, // Extended identifier
  output logic o_hit_valid, // Filter result pulse
  output logic o_hit, // Some filter accepted
  output logic [3:0] o_hit_filter, // Winning filter
  output logic [3:0] o_hit_buffer, // Buffer pointer of winner
  output logic o_hit_fifo // Winner steers to FIFO
);

  localparam int NF = cafs_pkg::NUM_FILT;
  localparam int NM = cafs_pkg::NUM_MASK;

  // Register contents
  logic [15:0] fen_reg;
  logic [15:0] msel_lo_reg;
  logic [15:0] msel_hi_reg;
  logic [15:0] bufp_reg [4];
  logic [15:0] msid_reg [NM];
  logic [15:0] meid_reg [NM];
  logic [15:0] fsid_reg [NF];
  logic [15:0] feid_reg [NF];
  logic [15:0] status_reg;
  logic [15:0] status_next;

  // Bus decode
  logic [11:0] addr;
  logic [3:0] idx;
  logic setup;
  logic wr_go;
  logic mapped;
  logic [31:0] rd_next;

  cafs_match_if mif ();

  // Merge a write by byte lane, reserved bits cleared
  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [31:0] wd,
    input logic [3:0] st,
    input logic [15:0] wmask
  );
    logic [15:0] r;
    r = old;
    if (st[0]) begin
      r[7:0] = wd[7:0];
    end
    if (st[1]) begin
      r[15:8] = wd[15:8];
    end
    return r & wmask;
  endfunction : merge16

  // Compare the upper address bits with a block base
  function automatic logic in_block(
    input logic [11:0] a,
    input logic [11:0] base,
    input int shift
  );
    return (a >> shift) == (base >> shift);
  endfunction : in_block

  // Lowest set bit of the hit vector
  function automatic logic [3:0] first_hit(input logic [15:0] h);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NF - 1; i >= 0; i--) begin
      if (h[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : first_hit

  // Address and strobe decode
  assign addr = 12'(i_paddr);
  assign idx = addr[5:2];
  assign setup = i_psel && !i_penable;
  assign wr_go = i_psel && i_penable && o_pready && i_pwrite && mapped;

  // Map check for every address
  always_comb begin
    mapped = 1'b0;
    if (addr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (addr < cafs_pkg::OFF_MSID_BASE) begin
      mapped = 1'b1;
    end else if (in_block(addr, cafs_pkg::OFF_MSID_BASE, 4) ||
                 in_block(addr, cafs_pkg::OFF_MEID_BASE, 4)) begin
      mapped = (addr[3:2] < 2'(NM));
    end else if (in_block(addr, cafs_pkg::OFF_FSID_BASE, 6) ||
                 in_block(addr, cafs_pkg::OFF_FEID_BASE, 6)) begin
      mapped = 1'b1;
    end
  end

  // Read data selection
  always_comb begin
    rd_next = 32'h0000_0000;
    case (addr)
      cafs_pkg::OFF_FEN: rd_next[15:0] = fen_reg;
      cafs_pkg::OFF_MSEL_LO: rd_next[15:0] = msel_lo_reg;
      cafs_pkg::OFF_MSEL_HI: rd_next[15:0] = msel_hi_reg;
      cafs_pkg::OFF_STATUS: rd_next[15:0] = status_reg;
      cafs_pkg::OFF_BUFP1: rd_next[15:0] = bufp_reg[0];
      cafs_pkg::OFF_BUFP2: rd_next[15:0] = bufp_reg[1];
      cafs_pkg::OFF_BUFP3: rd_next[15:0] = bufp_reg[2];
      cafs_pkg::OFF_BUFP4: rd_next[15:0] = bufp_reg[3];
      default: begin
        if (in_block(addr, cafs_pkg::OFF_MSID_BASE, 4) && mapped) begin
          rd_next[15:0] = msid_reg[addr[3:2]];
        end else if (in_block(addr, cafs_pkg::OFF_MEID_BASE, 4) &&
                     mapped) begin
          rd_next[15:0] = meid_reg[addr[3:2]];
        end else if (in_block(addr, cafs_pkg::OFF_FSID_BASE, 6)) begin
          rd_next[15:0] = fsid_reg[idx];
        end else if (in_block(addr, cafs_pkg::OFF_FEID_BASE, 6)) begin
          rd_next[15:0] = feid_reg[idx];
        end
      end
    endcase
  end

  // APB handshake: ready in the first access cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup && !mapped;
      if (setup && !i_pwrite) begin
        o_prdata <= rd_next;
      end
    end
  end

  // Enable word and mask selectors
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      fen_reg <= cafs_pkg::FEN_RST;
      msel_lo_reg <= cafs_pkg::MSEL_RST;
      msel_hi_reg <= cafs_pkg::MSEL_RST;
    end else if (wr_go) begin
      if (addr == cafs_pkg::OFF_FEN) begin
        fen_reg <= merge16(fen_reg, i_pwdata, i_pstrb, 16'hffff);
      end
      if (addr == cafs_pkg::OFF_MSEL_LO) begin
        msel_lo_reg <= merge16(msel_lo_reg, i_pwdata, i_pstrb, 16'hffff);
      end
      if (addr == cafs_pkg::OFF_MSEL_HI) begin
        msel_hi_reg <= merge16(msel_hi_reg, i_pwdata, i_pstrb, 16'hffff);
      end
    end
  end

  // Buffer pointer words
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int i = 0; i < 4; i++) begin
        bufp_reg[i] <= cafs_pkg::BUFP_RST;
      end
    end else if (wr_go) begin
      for (int i = 0; i < 4; i++) begin
        if (addr == cafs_pkg::OFF_BUFP1 + 12'(4 * i)) begin
          bufp_reg[i] <= merge16(bufp_reg[i], i_pwdata, i_pstrb, 16'hffff);
        end
      end
    end
  end

  // Mask identifier words
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NM; i++) begin
        msid_reg[i] <= cafs_pkg::IDENT_RST;
        meid_reg[i] <= cafs_pkg::IDENT_RST;
      end
    end else if (wr_go) begin
      if (in_block(addr, cafs_pkg::OFF_MSID_BASE, 4)) begin
        msid_reg[addr[3:2]] <= merge16(msid_reg[addr[3:2]], i_pwdata,
                                       i_pstrb, cafs_pkg::SID_WMASK);
      end
      if (in_block(addr, cafs_pkg::OFF_MEID_BASE, 4)) begin
        meid_reg[addr[3:2]] <= merge16(meid_reg[addr[3:2]], i_pwdata,
                                       i_pstrb, 16'hffff);
      end
    end
  end

  // Filter identifier words
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NF; i++) begin
        fsid_reg[i] <= cafs_pkg::IDENT_RST;
        feid_reg[i] <= cafs_pkg::IDENT_RST;
      end
    end else if (wr_go) begin
      if (in_block(addr, cafs_pkg::OFF_FSID_BASE, 6)) begin
        fsid_reg[idx] <= merge16(fsid_reg[idx], i_pwdata, i_pstrb,
                                 cafs_pkg::SID_WMASK);
      end
      if (in_block(addr, cafs_pkg::OFF_FEID_BASE, 6)) begin
        feid_reg[idx] <= merge16(feid_reg[idx], i_pwdata, i_pstrb,
                                 16'hffff);
      end
    end
  end

  // Feed the matcher
  assign mif.fr_ext = i_frame_ext;
  assign mif.fr_sid = i_frame_sid;
  assign mif.fr_eid = i_frame_eid;
  assign mif.fen = fen_reg;
  assign mif.msel = {msel_hi_reg, msel_lo_reg};
  always_comb begin
    for (int i = 0; i < NF; i++) begin
      mif.fsid[i] = fsid_reg[i];
      mif.feid[i] = feid_reg[i];
    end
    for (int i = 0; i < NM; i++) begin
      mif.msid[i] = msid_reg[i];
      mif.meid[i] = meid_reg[i];
    end
  end

  cafs_match u_match (
    .m (mif)
  );

  // Steering of the winning filter, pointer zero on a miss
  logic [3:0] win;
  logic [3:0] win_bp;
  logic any_hit;
  assign any_hit = |mif.hit;
  assign win = first_hit(mif.hit);
  assign win_bp = any_hit ? bufp_reg[win[3:2]][4*win[1:0] +: 4]
                          : 4'h0;

  // Status word reflects the last evaluated frame
  always_comb begin
    status_next = 16'h0000;
    status_next[cafs_pkg::ST_SEEN] = 1'b1;
    status_next[cafs_pkg::ST_HIT] = any_hit;
    status_next[cafs_pkg::ST_FIFO] = any_hit &&
                                     (win_bp == cafs_pkg::BP_FIFO);
    status_next[cafs_pkg::ST_FILT_LSB +: 4] = win;
    status_next[3:0] = win_bp;
  end

  // Result outputs, one cycle after the frame pulse
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_hit_valid <= 1'b0;
      o_hit <= 1'b0;
      o_hit_filter <= 4'h0;
      o_hit_buffer <= 4'h0;
      o_hit_fifo <= 1'b0;
      status_reg <= 16'h0000;
    end else begin
      o_hit_valid <= i_frame_valid;
      if (i_frame_valid) begin
        o_hit <= any_hit;
        o_hit_filter <= win;
        o_hit_buffer <= win_bp;
        o_hit_fifo <= any_hit && (win_bp == cafs_pkg::BP_FIFO);
        status_reg <= status_next;
      end
    end
  end

endmodule : cafs_top
`default_nettype wire
